// >>> ssr_pkg.sv
package ssr_pkg;
	// ---------------------------------------------------------------
	// register indices (byte address = 4 * index)
	// ---------------------------------------------------------------
	localparam logic [7:0] IDX_INT_CTRL = 8'h0b;
	localparam logic [7:0] IDX_IRQ_FLAGS = 8'h0c;
	localparam logic [7:0] IDX_IRQ_ENABLES = 8'h8c;
	localparam logic [7:0] IDX_RX_STATUS_CTRL = 8'h18;
	localparam logic [7:0] IDX_BAUD_DIVISOR = 8'h19;
	localparam logic [7:0] IDX_RX_FIFO = 8'h1a;
	localparam logic [7:0] IDX_SERIAL_MODE = 8'h1b;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int BIT_GLOBAL_IRQ_EN = 7;
	localparam int BIT_PERIPH_IRQ_EN = 6;
	localparam int BIT_RECEIVE_FLAG = 5;
	localparam int BIT_RECEIVE_IRQ_EN = 5;
	localparam int BIT_PORT_EN = 7;
	localparam int BIT_NINE_BIT_EN = 6;
	localparam int BIT_SINGLE_RX_EN = 5;
	localparam int BIT_CONT_RX_EN = 4;
	localparam int BIT_OVERRUN = 1;
	localparam int BIT_NINTH_RX = 0;
	localparam int BIT_CLK_SOURCE = 7;
	localparam int BIT_SYNC_MODE = 4;

	// ---------------------------------------------------------------
	// reset values and sizes
	// ---------------------------------------------------------------
	localparam logic [7:0] RST_INT_CTRL = 8'h00;
	localparam logic [7:0] RST_IRQ_FLAGS = 8'h00;
	localparam logic [7:0] RST_IRQ_ENABLES = 8'h00;
	localparam logic [7:0] RST_RX_STATUS_CTRL = 8'h00;
	localparam logic [7:0] RST_BAUD_DIVISOR = 8'h00;
	localparam logic [7:0] RST_SERIAL_MODE = 8'h00;
	localparam int DATA_BITS = 8;
	localparam int FIFO_DEPTH = 2;
	localparam int WB_ADR_BITS = 10;
endpackage

// >>> ssr_rxq_if.sv
`timescale 1ns/10ps
interface ssr_rxq_if #(
	parameter int WIDTH = 9
);
	logic push;
	logic [WIDTH-1:0] push_data;
	logic pop;
	logic [WIDTH-1:0] head;
	logic full;
	logic empty;

	modport producer (output push, output push_data, output pop, input head, input full, input empty);
	modport store (input push, input push_data, input pop, output head, output full, output empty);
endinterface

// >>> ssr_rx_fifo.sv
`timescale 1ns/10ps
module ssr_rx_fifo
	import ssr_pkg::*;
#(
	parameter int WIDTH = 9,
	parameter int DEPTH = FIFO_DEPTH
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// queue port
	ssr_rxq_if.store q
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);
	localparam logic [PW-1:0] LAST_C = PW'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [PW:0] count;
	logic do_push;
	logic do_pop;

	assign do_pop = q.pop && (count != '0);
	// a full queue refuses the word; caller flags the overrun
	assign do_push = q.push && (count != DEPTH_C); // [RULE_10]

	always_ff @(posedge ref_clk) begin
		if (do_push) begin
			mem[wr_ptr] <= q.push_data;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (do_push) begin
				wr_ptr <= (wr_ptr == LAST_C) ? '0 : wr_ptr + 1'b1;
			end
			if (do_pop) begin
				rd_ptr <= (rd_ptr == LAST_C) ? '0 : rd_ptr + 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			count <= '0;
		end else if (do_push && !do_pop) begin
			count <= count + 1'b1;
		end else if (do_pop && !do_push) begin
			count <= count - 1'b1;
		end
	end

	assign q.head = (count == '0) ? '0 : mem[rd_ptr];
	assign q.full = (count == DEPTH_C);
	assign q.empty = (count == '0);
endmodule

// >>> ssr_master_rx.sv
// Functional notes
// [RULE_01] In sync mode, reception starts when single or continuous enable is set.
// [RULE_02] Data line is sampled on each falling edge of the generated clock.
// [RULE_03] Single enable alone receives exactly one word, then clocking stops.
// [RULE_04] Continuous enable receives words back to back until software clears it.
// [RULE_05] With both enables set, continuous reception wins.
// [RULE_06] After the last bit the shifted word moves into the queue if room.
// [RULE_07] A word entering the queue sets the receive flag, flags bit 5.
// [RULE_08] Receive interrupt request only while enables bit 5 is set.
// [RULE_09] Receive flag is read-only, cleared by hardware once the queue is empty.
// [RULE_10] Queue holds two words; a third may shift in meanwhile.
// [RULE_11] Queue still full at a third word's last bit sets overrun, word dropped.
// [RULE_12] Overrun clears only when software clears the continuous enable.
// [RULE_13] While overrun is set, no word enters the queue.
// [RULE_14] Ninth bit queues with its word; a data read exposes the next one.
// [RULE_15] Software reads status before data for the same word.
// [RULE_16] Software may read data twice to drain both queued words.
// [RULE_17] Setup order: divisor, then mode/port/clock source, then irq and nine-bit.
// [RULE_18] Software clears both enables before setup, then sets one.
// [RULE_19] Global and peripheral irq enables must also be set for the processor.
// [RULE_20] Serial clock runs at the divisor rate only while reception runs.
`timescale 1ns/10ps
module ssr_master_rx
	import ssr_pkg::*;
#(
	parameter int QUEUE_DEPTH = FIFO_DEPTH
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// wishbone slave
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_we,
	input wire logic [WB_ADR_BITS-1:0] wb_adr,
	input wire logic [3:0] wb_sel,
	input wire logic [31:0] wb_wdata,
	output logic [31:0] wb_rdata,
	output logic wb_ack,
	// serial link
	output logic serial_clk_out,
	output logic serial_clk_oe,
	input wire logic serial_data_in,
	output logic serial_data_out,
	output logic serial_data_oe,
	// interrupt request
	output logic rx_irq
);
	typedef enum logic {
		ST_IDLE,
		ST_SHIFT
	} ssr_state_e;

	// ---------------------------------------------------------------
	// registers and state
	// ---------------------------------------------------------------
	logic [7:0] interrupt_control;
	logic [7:0] peripheral_irq_flags;
	logic [7:0] peripheral_irq_enables;
	logic [7:0] baud_divisor;
	logic [7:0] serial_mode;
	logic serial_port_enable;
	logic nine_bit_receive_enable;
	logic single_receive_enable;
	logic continuous_receive_enable;
	logic overrun_error_flag;
	logic receive_flag;
	logic ninth_rx_bit;
	ssr_state_e state;
	logic [7:0] div_cnt;
	logic clk_q;
	logic [3:0] bit_cnt;
	logic [DATA_BITS:0] receive_shift_register;
	logic word_done;
	logic word_done_q;
	logic din_meta;
	logic din_sync;

	// ---------------------------------------------------------------
	// bus decode
	// ---------------------------------------------------------------
	logic [7:0] idx;
	logic req;
	logic acc;
	logic wr_acc;
	logic rd_fifo;
	logic [7:0] next_rdata;
	logic [7:0] rx_status_byte;

	ssr_rxq_if #(.WIDTH(DATA_BITS + 1)) rxq ();

	ssr_rx_fifo #(
		.WIDTH(DATA_BITS + 1),
		.DEPTH(QUEUE_DEPTH)
	) u_fifo (
		.ref_clk(ref_clk),
		.rst(rst),
		.q(rxq.store)
	);

	assign idx = wb_adr[WB_ADR_BITS-1:2];
	assign req = wb_cyc && wb_stb;
	// writes and pops act at the edge where the master sees ack
	assign acc = req && wb_ack;
	assign wr_acc = acc && wb_we && wb_sel[0];
	assign rd_fifo = acc && !wb_we && (idx == IDX_RX_FIFO);

	always_comb begin
		rx_status_byte = 8'h00;
		rx_status_byte[BIT_PORT_EN] = serial_port_enable;
		rx_status_byte[BIT_NINE_BIT_EN] = nine_bit_receive_enable;
		rx_status_byte[BIT_SINGLE_RX_EN] = single_receive_enable;
		rx_status_byte[BIT_CONT_RX_EN] = continuous_receive_enable;
		rx_status_byte[BIT_OVERRUN] = overrun_error_flag;
		rx_status_byte[BIT_NINTH_RX] = ninth_rx_bit;
	end

	always_comb begin
		case (idx)
			IDX_INT_CTRL: next_rdata = interrupt_control;
			IDX_IRQ_FLAGS: next_rdata = peripheral_irq_flags | (8'(receive_flag) << BIT_RECEIVE_FLAG); // [RULE_07]
			IDX_IRQ_ENABLES: next_rdata = peripheral_irq_enables;
			IDX_RX_STATUS_CTRL: next_rdata = rx_status_byte;
			IDX_BAUD_DIVISOR: next_rdata = baud_divisor;
			IDX_RX_FIFO: next_rdata = rxq.head[DATA_BITS-1:0];
			IDX_SERIAL_MODE: next_rdata = serial_mode;
			default: next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wb_ack <= 1'b0;
		end else begin
			wb_ack <= req && !wb_ack;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wb_rdata <= 32'h0000_0000;
		end else if (req && !wb_ack && !wb_we) begin
			wb_rdata <= {24'h00_0000, next_rdata};
		end
	end

	// ---------------------------------------------------------------
	// software registers
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			interrupt_control <= RST_INT_CTRL;
			peripheral_irq_enables <= RST_IRQ_ENABLES;
			baud_divisor <= RST_BAUD_DIVISOR;
			serial_mode <= RST_SERIAL_MODE;
			serial_port_enable <= RST_RX_STATUS_CTRL[BIT_PORT_EN];
			nine_bit_receive_enable <= RST_RX_STATUS_CTRL[BIT_NINE_BIT_EN];
			continuous_receive_enable <= RST_RX_STATUS_CTRL[BIT_CONT_RX_EN];
		end else if (wr_acc) begin
			case (idx)
				IDX_INT_CTRL: interrupt_control <= wb_wdata[7:0];
				IDX_IRQ_ENABLES: peripheral_irq_enables <= wb_wdata[7:0];
				IDX_BAUD_DIVISOR: baud_divisor <= wb_wdata[7:0];
				IDX_SERIAL_MODE: serial_mode <= wb_wdata[7:0];
				IDX_RX_STATUS_CTRL: begin
					serial_port_enable <= wb_wdata[BIT_PORT_EN];
					nine_bit_receive_enable <= wb_wdata[BIT_NINE_BIT_EN];
					continuous_receive_enable <= wb_wdata[BIT_CONT_RX_EN];
				end
				default: ;
			endcase
		end
	end

	// hardware drops the single enable after its word; a write in that cycle wins
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			single_receive_enable <= RST_RX_STATUS_CTRL[BIT_SINGLE_RX_EN];
		end else if (wr_acc && idx == IDX_RX_STATUS_CTRL) begin
			single_receive_enable <= wb_wdata[BIT_SINGLE_RX_EN];
		end else if (word_done && !continuous_receive_enable) begin
			single_receive_enable <= 1'b0; // [RULE_03]
		end
	end

	// only the receive flag is hardware owned; other flag bits are plain storage
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			peripheral_irq_flags <= RST_IRQ_FLAGS;
		end else if (wr_acc && idx == IDX_IRQ_FLAGS) begin
			peripheral_irq_flags <= wb_wdata[7:0] & ~(8'h01 << BIT_RECEIVE_FLAG); // [RULE_09]
		end
	end

	// ---------------------------------------------------------------
	// data pin synchroniser
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			din_meta <= 1'b0;
			din_sync <= 1'b0;
		end else begin
			din_meta <= serial_data_in;
			din_sync <= din_meta;
		end
	end

	// ---------------------------------------------------------------
	// master clock generator and shifter
	// ---------------------------------------------------------------
	logic sync_master;
	logic run;
	logic half_tick;
	logic last_bit;

	assign sync_master = serial_port_enable && serial_mode[BIT_SYNC_MODE] && serial_mode[BIT_CLK_SOURCE];
	assign run = sync_master && (single_receive_enable || continuous_receive_enable); // [RULE_01]
	assign half_tick = (state == ST_SHIFT) && (div_cnt == 8'h00);
	assign last_bit = (bit_cnt == (nine_bit_receive_enable ? 4'(DATA_BITS) : 4'(DATA_BITS - 1)));
	// falling edge of the generated clock is the sample point
	assign word_done = half_tick && clk_q && last_bit && run; // [RULE_02]

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state <= ST_IDLE;
			div_cnt <= 8'h00;
			clk_q <= 1'b0;
			bit_cnt <= 4'h0;
		end else begin
			case (state)
				ST_IDLE: begin
					clk_q <= 1'b0;
					bit_cnt <= 4'h0;
					div_cnt <= baud_divisor;
					if (run) begin
						state <= ST_SHIFT; // [RULE_01]
					end
				end
				ST_SHIFT: begin
					if (!run) begin
						// enable cleared mid-word: the partial word is dropped
						state <= ST_IDLE;
						clk_q <= 1'b0;
					end else if (half_tick) begin
						div_cnt <= baud_divisor; // [RULE_20]
						clk_q <= ~clk_q;
						if (clk_q) begin
							if (last_bit) begin
								bit_cnt <= 4'h0;
								// continuous has priority over single
								if (!continuous_receive_enable) begin
									state <= ST_IDLE; // [RULE_03] [RULE_05]
								end
							end else begin
								bit_cnt <= bit_cnt + 4'h1; // [RULE_04]
							end
						end
					end else begin
						div_cnt <= div_cnt - 8'h01;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// lsb first; the ninth bit lands in the top position
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			receive_shift_register <= '0;
		end else if (half_tick && clk_q && run) begin
			receive_shift_register[bit_cnt] <= din_sync; // [RULE_02]
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			word_done_q <= 1'b0;
		end else begin
			word_done_q <= word_done;
		end
	end

	// ---------------------------------------------------------------
	// queue transfer, overrun and flags
	// ---------------------------------------------------------------
	logic overrun_hit;

	assign overrun_hit = word_done_q && !overrun_error_flag && rxq.full; // [RULE_11]
	assign rxq.push = word_done_q && !overrun_error_flag && !rxq.full; // [RULE_06] [RULE_13]
	assign rxq.push_data = {nine_bit_receive_enable && receive_shift_register[DATA_BITS],
		receive_shift_register[DATA_BITS-1:0]}; // [RULE_14]
	assign rxq.pop = rd_fifo; // [RULE_14]

	// set wins over the clear made by dropping the continuous enable
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			overrun_error_flag <= RST_RX_STATUS_CTRL[BIT_OVERRUN];
		end else if (overrun_hit) begin
			overrun_error_flag <= 1'b1; // [RULE_11]
		end else if (!continuous_receive_enable) begin
			overrun_error_flag <= 1'b0; // [RULE_12]
		end
	end

	assign receive_flag = !rxq.empty; // [RULE_07] [RULE_09]
	assign ninth_rx_bit = rxq.head[DATA_BITS]; // [RULE_14]
	assign rx_irq = receive_flag && peripheral_irq_enables[BIT_RECEIVE_IRQ_EN]
		&& interrupt_control[BIT_GLOBAL_IRQ_EN] && interrupt_control[BIT_PERIPH_IRQ_EN]; // [RULE_08] [RULE_19]

	// ---------------------------------------------------------------
	// pins
	// ---------------------------------------------------------------
	assign serial_clk_out = clk_q; // [RULE_20]
	assign serial_clk_oe = sync_master;
	// receive only: the data pin is never driven
	assign serial_data_out = 1'b0;
	assign serial_data_oe = 1'b0;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	logic [8:0] flag_view;
	assign flag_view = {1'b0, peripheral_irq_flags} | (9'(receive_flag) << BIT_RECEIVE_FLAG);

	start_recv_a: assert property (state == ST_IDLE && run |=> state == ST_SHIFT) // [RULE_01]
		else $error("reception did not start");
	sample_fall_a: assert property (state == ST_SHIFT && $past(state) == ST_SHIFT && bit_cnt == $past(bit_cnt) + 4'h1
		|-> $fell(clk_q)) // [RULE_02]
		else $error("bit taken off a falling clock edge");
	single_stop_a: assert property (word_done && !continuous_receive_enable
		&& !(wr_acc && idx == IDX_RX_STATUS_CTRL) |=> !single_receive_enable && state == ST_IDLE) // [RULE_03]
		else $error("single reception kept clocking");
	cont_keep_a: assert property (word_done && continuous_receive_enable && !wr_acc
		|=> state == ST_SHIFT && bit_cnt == 4'h0) // [RULE_04] [RULE_05]
		else $error("continuous reception stopped");
	push_word_a: assert property (word_done && !overrun_error_flag && rxq.empty |-> ##2 !rxq.empty) // [RULE_06]
		else $error("finished word went nowhere");
	flag_set_a: assert property (rxq.push |=> flag_view[BIT_RECEIVE_FLAG]) // [RULE_07]
		else $error("receive flag not set");
	irq_gate_a: assert property (rx_irq |-> peripheral_irq_enables[BIT_RECEIVE_IRQ_EN] && flag_view[BIT_RECEIVE_FLAG]) // [RULE_08]
		else $error("irq without enable");
	flag_clear_a: assert property (rd_fifo && !rxq.full && !rxq.push |=> !flag_view[BIT_RECEIVE_FLAG]) // [RULE_09]
		else $error("receive flag stuck");
	overrun_set_a: assert property (word_done_q && rxq.full && !overrun_error_flag
		|=> overrun_error_flag || !$past(continuous_receive_enable, 1) ) // [RULE_11] [RULE_10]
		else $error("overrun not flagged");
	overrun_clear_a: assert property (overrun_error_flag && !continuous_receive_enable && !overrun_hit
		|=> !overrun_error_flag) // [RULE_12]
		else $error("overrun not cleared");
	overrun_block_a: assert property (overrun_error_flag && rxq.empty |=> rxq.empty) // [RULE_13]
		else $error("word queued during overrun");
	idle_clock_a: assert property (state == ST_IDLE |=> !serial_clk_out) // [RULE_20]
		else $error("clock running while idle");
	clk_rate_a: assert property (state == ST_SHIFT && run && $changed(clk_q) && baud_divisor == 8'h04
		&& !wr_acc |=> (!$changed(clk_q) || !run) [*4] ##1 ($changed(clk_q) || !run)) // [RULE_20]
		else $error("clock half period wrong");

	single_word_c: cover property (state == ST_IDLE && single_receive_enable ##1 state == ST_SHIFT);
	two_words_c: cover property (rxq.full && !overrun_error_flag);
	overrun_c: cover property (overrun_hit);
	ninth_c: cover property (rd_fifo && ninth_rx_bit);
endmodule

// >>> ssr_link_partner.sv
`timescale 1ns/10ps
module ssr_link_partner (
	// serial link
	input wire logic serial_clk,
	input wire logic serial_clk_oe,
	output logic serial_data,
	// stimulus from the bench
	input wire logic restart,
	input wire logic nine_bits,
	input wire logic [35:0] words
);
	int bit_idx;
	int word_idx;
	logic last_bit = 1'b0;

	// -----------------------------------------------------------
	// word source
	// -----------------------------------------------------------
	// new bit only after a rising edge, so it stays put across the fall
	always @(posedge serial_clk or posedge restart) begin
		if (restart) begin
			bit_idx <= 0;
			word_idx <= 0;
		end else begin
			last_bit <= words[word_idx * 9 + bit_idx];
			if (bit_idx == (nine_bits ? 8 : 7)) begin
				bit_idx <= 0;
				word_idx <= (word_idx + 1) % 4;
			end else begin
				bit_idx <= bit_idx + 1;
			end
		end
	end

	// released line shows the inverse of the last bit
	assign serial_data = serial_clk_oe ? last_bit : ~last_bit;
endmodule

// >>> sync_serial_master_receive_bench.sv
`timescale 1ns/10ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin err_total++; \
	$display("unexpected at %0t: got %h want %h", $time, got, exp); end end
module sync_serial_master_receive_bench;
	import ssr_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [WB_ADR_BITS-1:0] wb_adr = '0;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_wdata = 32'h0;
	logic [31:0] wb_rdata;
	logic wb_ack;
	logic serial_clk_out;
	logic serial_clk_oe;
	logic serial_data;
	logic data_oe;
	logic rx_irq;
	logic restart = 1'b0;
	logic nine = 1'b0;
	// word 0 sits in the low nine bits
	logic [35:0] words = {9'h15a, 9'h0c3, 9'h03c, 9'h1a5};
	logic [7:0] rd;
	int err_total = 0;
	int compares = 0;
	int g;

	always #5 ref_clk = ~ref_clk;

	ssr_master_rx u_ssr_master_rx (
		.ref_clk(ref_clk), .rst(rst),
		.wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
		.wb_wdata(wb_wdata), .wb_rdata(wb_rdata), .wb_ack(wb_ack),
		.serial_clk_out(serial_clk_out), .serial_clk_oe(serial_clk_oe), .serial_data_in(serial_data),
		.serial_data_out(), .serial_data_oe(data_oe), .rx_irq(rx_irq)
	);

	ssr_link_partner u_ssr_link_partner (
		.serial_clk(serial_clk_out), .serial_clk_oe(serial_clk_oe), .serial_data(serial_data),
		.restart(restart), .nine_bits(nine), .words(words)
	);

	// -----------------------------------------------------------
	// bus and link tasks
	// -----------------------------------------------------------
	task tally_and_finish;
		if (err_total == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task xfer(input logic we, input logic [7:0] idx, input logic [7:0] wd);
		int n;
		n = 0;
		@(posedge ref_clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= {idx, 2'b00};
		wb_sel <= 4'hf;
		wb_wdata <= {24'h0, wd};
		do begin
			@(posedge ref_clk);
			n++;
		end while (wb_ack !== 1'b1 && n < 20);
		if (n >= 20) begin
			err_total++;
			$display("unexpected at %0t: no bus answer", $time);
			tally_and_finish();
		end
		rd = wb_rdata[7:0];
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
	endtask

	task wait_flag;
		int i;
		for (i = 0; i < 80; i++) begin
			xfer(1'b0, IDX_IRQ_FLAGS, 8'h00);
			if (rd[BIT_RECEIVE_FLAG] === 1'b1)
				break;
		end
		if (rd[BIT_RECEIVE_FLAG] !== 1'b1) begin
			err_total++;
			$display("unexpected at %0t: no word arrived", $time);
			tally_and_finish();
		end
	endtask

	// counts ref cycles between two rising link clock edges
	task rise_gap(output int gap);
		int i;
		logic p;
		gap = 0;
		p = serial_clk_out;
		for (i = 0; i < 100; i++) begin
			@(posedge ref_clk);
			if (serial_clk_out && !p)
				break;
			p = serial_clk_out;
		end
		p = serial_clk_out;
		for (i = 0; i < 100; i++) begin
			@(posedge ref_clk);
			gap++;
			if (serial_clk_out && !p)
				break;
			p = serial_clk_out;
		end
	endtask

	task pulse_restart;
		restart <= 1'b1;
		@(posedge ref_clk);
		restart <= 1'b0;
	endtask

	// -----------------------------------------------------------
	// scenarios
	// -----------------------------------------------------------
	initial begin
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		xfer(1'b0, IDX_IRQ_FLAGS, 8'h00);
		`CHK(rd, 8'h00)
		xfer(1'b0, IDX_IRQ_ENABLES, 8'h00);
		`CHK(rd, 8'h00)
		xfer(1'b0, IDX_RX_STATUS_CTRL, 8'h00);
		`CHK(rd, 8'h00)
		`CHK(serial_clk_oe, 1'b0)
		xfer(1'b1, 8'h30, 8'hff);
		xfer(1'b0, 8'h30, 8'h00);
		`CHK(rd, 8'h00)
		xfer(1'b1, IDX_RX_STATUS_CTRL, 8'h00);
		xfer(1'b1, IDX_BAUD_DIVISOR, 8'h04);
		xfer(1'b1, IDX_SERIAL_MODE, 8'h90);
		xfer(1'b1, IDX_RX_STATUS_CTRL, 8'h80);
		repeat (20) @(posedge ref_clk);
		`CHK(serial_clk_out, 1'b0)
		`CHK(serial_clk_oe, 1'b1)
		`CHK(data_oe, 1'b0)
		// single word, then the link must stay quiet
		pulse_restart();
		xfer(1'b1, IDX_RX_STATUS_CTRL, 8'ha0);
		wait_flag();
		xfer(1'b1, IDX_IRQ_FLAGS, 8'h00);
		xfer(1'b0, IDX_IRQ_FLAGS, 8'h00);
		`CHK(rd[BIT_RECEIVE_FLAG], 1'b1)
		xfer(1'b0, IDX_RX_STATUS_CTRL, 8'h00);
		`CHK(rd & 8'h30, 8'h00)
		rise_gap(g);
		`CHK(g, 100)
		xfer(1'b0, IDX_RX_FIFO, 8'h00);
		`CHK(rd, 8'ha5)
		xfer(1'b0, IDX_IRQ_FLAGS, 8'h00);
		`CHK(rd[BIT_RECEIVE_FLAG], 1'b0)
		// interrupt request follows its enable
		xfer(1'b1, IDX_IRQ_ENABLES, 8'h20);
		xfer(1'b1, IDX_INT_CTRL, 8'hc0);
		pulse_restart();
		xfer(1'b1, IDX_RX_STATUS_CTRL, 8'ha0);
		wait_flag();
		@(negedge ref_clk);
		`CHK(rx_irq, 1'b1)
		xfer(1'b1, IDX_IRQ_ENABLES, 8'h00);
		@(negedge ref_clk);
		`CHK(rx_irq, 1'b0)
		xfer(1'b0, IDX_RX_FIFO, 8'h00);
		`CHK(rd, 8'ha5)
		// nine bits, both enables, overrun on the third word
		nine <= 1'b1;
		pulse_restart();
		xfer(1'b1, IDX_RX_STATUS_CTRL, 8'hf0);
		rise_gap(g);
		`CHK(g, 10)
		repeat (400) @(posedge ref_clk);
		xfer(1'b0, IDX_RX_STATUS_CTRL, 8'h00);
		`CHK(rd[1:0], 2'b11)
		xfer(1'b0, IDX_RX_FIFO, 8'h00);
		`CHK(rd, 8'ha5)
		xfer(1'b0, IDX_RX_STATUS_CTRL, 8'h00);
		`CHK(rd[BIT_NINTH_RX], 1'b0)
		xfer(1'b0, IDX_RX_FIFO, 8'h00);
		`CHK(rd, 8'h3c)
		repeat (150) @(posedge ref_clk);
		xfer(1'b0, IDX_IRQ_FLAGS, 8'h00);
		`CHK(rd[BIT_RECEIVE_FLAG], 1'b0)
		xfer(1'b1, IDX_RX_STATUS_CTRL, 8'hc0);
		xfer(1'b0, IDX_RX_STATUS_CTRL, 8'h00);
		`CHK(rd[BIT_OVERRUN], 1'b0)
		tally_and_finish();
	end
endmodule
